// ==== common/cpu_core_pkg.sv ====
// Constants, encodings and layouts for the CPU working-register core
package cpu_core_pkg;
  // Register file geometry
  localparam int NUM_REGS = 32;
  localparam int REG_AW = 5;
  // Pointer pair base indices (low byte index, high byte is +1)
  localparam logic [4:0] PTR_X_LO = 5'h1a;
  localparam logic [4:0] PTR_Y_LO = 5'h1c;
  localparam logic [4:0] PTR_Z_LO = 5'h1e;
  // Data space map
  localparam logic [15:0] DS_IO_BASE = 16'h0020;
  localparam logic [15:0] DS_IO_LAST = 16'h005f;
  localparam logic [15:0] DS_EXT_LAST = 16'h00ff;
  // I/O addresses of the flag and stack registers (own choice)
  localparam logic [5:0] IO_STACK_LOW = 6'h3d;
  localparam logic [5:0] IO_STACK_HIGH = 6'h3e;
  localparam logic [5:0] IO_FLAGS = 6'h3f;
  // Flag bit positions
  localparam int FLAG_I = 7;
  localparam int FLAG_T = 6;
  localparam int FLAG_H = 5;
  localparam int FLAG_S = 4;
  localparam int FLAG_V = 3;
  localparam int FLAG_N = 2;
  localparam int FLAG_Z = 1;
  localparam int FLAG_C = 0;
  // Reset values
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] SP_HIGH_RESET = 8'h20;
  localparam logic [7:0] SP_LOW_RESET = 8'hff;
  // Stack step sizes
  localparam logic [15:0] SP_STEP_BYTE = 16'h0001;
  localparam logic [15:0] SP_STEP_RET = 16'h0003;
  // Stack operations
  typedef enum logic [2:0] {
    SP_NONE, SP_PUSH, SP_POP, SP_CALL, SP_RET
  } sp_op_t;
  // Pointer update modes
  typedef enum logic [1:0] {
    PTR_DISP, PTR_POSTINC, PTR_PREDEC
  } ptr_mode_t;
  // Write-back schemes
  typedef enum logic [1:0] {
    WB_NONE, WB_BYTE, WB_WORD
  } wb_kind_t;
  // Data space region
  typedef enum logic [1:0] {
    REGION_REGS, REGION_IO, REGION_EXT, REGION_SRAM
  } region_t;
endpackage : cpu_core_pkg

// ==== common/fetch_if.sv ====
// Interface between the core and its instruction prefetch stage
`timescale 1ns/1ps
`default_nettype none
interface fetch_if;
  logic [15:0] pc;
  logic [15:0] word;
  logic valid;
  logic advance;
  logic [15:0] jump_pc;
  logic jump;
  modport core (input word, valid, pc, output advance, jump, jump_pc);
  modport fetch (output word, valid, pc, input advance, jump, jump_pc);
endinterface : fetch_if
`default_nettype wire

// ==== core/insn_prefetch.sv ====
// Single-level instruction prefetch stage
`timescale 1ns/1ps
`default_nettype none
module insn_prefetch (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Program memory
  output logic [15:0] pm_addr,
  input wire logic [15:0] pm_data,
  // Core side
  fetch_if.fetch fi
);
  logic [15:0] fetch_pc, next_fetch_pc; // Address being fetched
  logic [15:0] held_word, next_held_word; // Prefetched word
  logic [15:0] held_pc, next_held_pc; // Address of prefetched word
  logic held_valid, next_held_valid; // Prefetch register full

  // Fetch the next word while the core executes the held one
  always_comb begin
    next_fetch_pc = fetch_pc;
    next_held_word = held_word;
    next_held_pc = held_pc;
    next_held_valid = held_valid;
    if (fi.jump) begin
      // Redirect drops the stale prefetch
      next_fetch_pc = fi.jump_pc;
      next_held_valid = 1'b0;
    end else if (fi.advance || !held_valid) begin
      next_held_word = pm_data;
      next_held_pc = fetch_pc;
      next_held_valid = 1'b1;
      next_fetch_pc = fetch_pc + 16'h0001;
    end
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_pc <= 16'h0000;
      held_word <= 16'h0000;
      held_pc <= 16'h0000;
      held_valid <= 1'b0;
    end else begin
      fetch_pc <= next_fetch_pc;
      held_word <= next_held_word;
      held_pc <= next_held_pc;
      held_valid <= next_held_valid;
    end
  end

  assign pm_addr = fetch_pc;
  assign fi.word = held_word;
  assign fi.pc = held_pc;
  assign fi.valid = held_valid;
endmodule : insn_prefetch
`default_nettype wire

// ==== core/cpu_core_regs.sv ====
// Working registers, flags, pointers and stack pointer of the CPU core
`timescale 1ns/1ps
`default_nettype none
module cpu_core_regs import cpu_core_pkg::*; #(
  parameter logic [15:0] SRAM_LAST = {SP_HIGH_RESET, SP_LOW_RESET}
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Program memory
  output logic [15:0] pm_addr,
  input wire logic [15:0] pm_data,
  output logic [15:0] insn_word,
  output logic [15:0] insn_pc,
  output logic insn_valid,
  input wire logic insn_advance,
  input wire logic jump,
  input wire logic [15:0] jump_pc,
  // Operand read ports
  input wire logic [4:0] rd_addr_a,
  input wire logic [4:0] rd_addr_b,
  output logic [7:0] rd_data_a,
  output logic [7:0] rd_data_b,
  output logic [15:0] rd_word_a,
  // Result write-back
  input wire wb_kind_t wb_kind,
  input wire logic [4:0] wb_addr,
  input wire logic [15:0] wb_data,
  // ALU flag update
  input wire logic alu_flags_we,
  input wire logic [7:0] alu_flags_mask,
  input wire logic alu_h,
  input wire logic alu_v,
  input wire logic alu_n,
  input wire logic alu_z,
  input wire logic alu_c,
  // Bit copy
  input wire logic bit_store_op,
  input wire logic bit_load_op,
  input wire logic [2:0] bit_sel,
  // Interrupt enable control
  input wire logic irq_enter,
  input wire logic irq_return_op,
  input wire logic ie_set_op,
  input wire logic ie_clear_op,
  input wire logic irq_request,
  output logic irq_allowed,
  // Pointer access
  input wire logic ptr_use,
  input wire logic [1:0] ptr_sel,
  input wire ptr_mode_t ptr_mode,
  input wire logic [5:0] ptr_disp,
  output logic [15:0] ptr_ea,
  // Data space access
  input wire logic ds_req,
  input wire logic ds_we,
  input wire logic ds_direct_io,
  input wire logic [15:0] ds_addr,
  input wire logic [7:0] ds_wdata,
  output logic [7:0] ds_rdata,
  output logic ds_refused,
  // External I/O and SRAM
  output logic io_req,
  output logic io_we,
  output logic [7:0] io_addr,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  output logic sram_req,
  output logic [15:0] sram_addr,
  // Stack
  input wire sp_op_t sp_op,
  output logic [15:0] stack_pointer,
  output logic [7:0] cpu_flags
);
  logic rst_meta, rst_n; // Reset release synchroniser
  logic [7:0] regs [NUM_REGS]; // Working registers
  logic [7:0] next_regs [NUM_REGS];
  logic [7:0] next_cpu_flags;
  logic [7:0] stack_pointer_high, next_stack_pointer_high;
  logic [7:0] stack_pointer_low, next_stack_pointer_low;
  logic [15:0] ptr_val; // Selected pointer value
  logic [15:0] ptr_new; // Pointer after update
  logic [4:0] ptr_lo; // Index of selected pointer low byte
  region_t region; // Decoded data space region
  logic [5:0] io_idx; // I/O index of the access
  logic local_io; // Access hits flags or stack pointer
  fetch_if fi();

  // Reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  insn_prefetch u_fetch (
    .clk(clk),
    .rst_n(rst_n),
    .pm_addr(pm_addr),
    .pm_data(pm_data),
    .fi(fi)
  );
  assign fi.advance = insn_advance;
  assign fi.jump = jump;
  assign fi.jump_pc = jump_pc;
  assign insn_word = fi.word;
  assign insn_pc = fi.pc;
  assign insn_valid = fi.valid;

  // Classify a data space address
  function automatic region_t region_of(input logic [15:0] a);
    if (a < DS_IO_BASE) region_of = REGION_REGS;
    else if (a <= DS_IO_LAST) region_of = REGION_IO;
    else if (a <= DS_EXT_LAST) region_of = REGION_EXT;
    else region_of = REGION_SRAM;
  endfunction : region_of

  always_comb begin
    case (ptr_sel)
      2'd0: ptr_lo = PTR_X_LO;
      2'd1: ptr_lo = PTR_Y_LO;
      default: ptr_lo = PTR_Z_LO;
    endcase
    ptr_val = {regs[ptr_lo + 5'd1], regs[ptr_lo]};
  end

  always_comb begin
    ptr_new = ptr_val;
    ptr_ea = ptr_val;
    case (ptr_mode)
      PTR_DISP: ptr_ea = ptr_val + {10'h000, ptr_disp};
      PTR_POSTINC: ptr_new = ptr_val + 16'h0001;
      PTR_PREDEC: begin
        ptr_new = ptr_val - 16'h0001;
        ptr_ea = ptr_new;
      end
      default: ptr_ea = ptr_val;
    endcase
  end

  // direct I/O index or data address map onto the I/O space
  always_comb begin
    region = ds_direct_io ? REGION_IO : region_of(ds_addr);
    io_idx = ds_direct_io ? ds_addr[5:0]
                          : 6'(ds_addr - DS_IO_BASE);
    // short I/O form cannot reach past the 64 addresses
    ds_refused = ds_req && ds_direct_io && (ds_addr > 16'h003f);
    // A refused access must not reach the local registers either
    local_io = !ds_refused && (region == REGION_IO) &&
               (io_idx == IO_FLAGS || io_idx == IO_STACK_LOW ||
                io_idx == IO_STACK_HIGH);
  end

  // Read ports are combinational for single-cycle access
  always_comb begin
    // two operands out in the same cycle
    rd_data_a = regs[rd_addr_a];
    rd_data_b = regs[rd_addr_b];
    // 16-bit operand from an even pair
    rd_word_a = {regs[{rd_addr_a[4:1], 1'b1}],
                 regs[{rd_addr_a[4:1], 1'b0}]};
    ds_rdata = 8'h00;
    case (region)
      // registers in the first 32 addresses
      REGION_REGS: ds_rdata = regs[ds_addr[4:0]];
      REGION_IO: begin
        if (io_idx == IO_FLAGS) ds_rdata = cpu_flags;
        else if (io_idx == IO_STACK_LOW) ds_rdata = stack_pointer_low;
        else if (io_idx == IO_STACK_HIGH)
          ds_rdata = stack_pointer_high;
        else ds_rdata = io_rdata;
      end
      REGION_EXT: ds_rdata = io_rdata;
      default: ds_rdata = 8'h00;
    endcase
  end

  // External I/O strobes; local registers are not forwarded
  always_comb begin
    io_req = ds_req && !ds_refused && !local_io &&
             (region == REGION_IO || region == REGION_EXT);
    io_we = io_req && ds_we;
    io_addr = (region == REGION_IO) ? {2'b00, io_idx} + 8'h20
                                   : ds_addr[7:0];
    io_wdata = ds_wdata;
    sram_req = ds_req && !ds_refused && (region == REGION_SRAM);
    sram_addr = ds_addr;
  end

  // Register file next state
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      next_regs[i] = regs[i];
    end
    if (wb_kind == WB_BYTE) begin
      next_regs[wb_addr] = wb_data[7:0];
    end else if (wb_kind == WB_WORD) begin
      // 16-bit result to an even pair
      next_regs[{wb_addr[4:1], 1'b0}] = wb_data[7:0];
      next_regs[{wb_addr[4:1], 1'b1}] = wb_data[15:8];
    end
    // bit load from the copy flag
    if (bit_load_op) begin
      next_regs[wb_addr][bit_sel] = cpu_flags[FLAG_T];
    end
    // Pointer update lands after any result write
    if (ptr_use && ptr_mode != PTR_DISP) begin
      next_regs[ptr_lo] = ptr_new[7:0];
      next_regs[ptr_lo + 5'd1] = ptr_new[15:8];
    end
    // data space store to a register
    if (ds_req && ds_we && !ds_refused && region == REGION_REGS) begin
      next_regs[ds_addr[4:0]] = ds_wdata;
    end
  end

  // Register file storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= next_regs[i];
      end
    end
  end

  // Flags next state
  // interrupt entry and return never touch the other flags
  always_comb begin
    next_cpu_flags = cpu_flags;
    // Software write first, hardware events take priority after it
    if (ds_req && ds_we && local_io && io_idx == IO_FLAGS) begin
      next_cpu_flags = ds_wdata;
    end
    // masked update from the ALU result
    if (alu_flags_we) begin
      if (alu_flags_mask[FLAG_H]) next_cpu_flags[FLAG_H] = alu_h;
      if (alu_flags_mask[FLAG_V]) next_cpu_flags[FLAG_V] = alu_v;
      if (alu_flags_mask[FLAG_N]) next_cpu_flags[FLAG_N] = alu_n;
      if (alu_flags_mask[FLAG_Z]) next_cpu_flags[FLAG_Z] = alu_z;
      if (alu_flags_mask[FLAG_C]) next_cpu_flags[FLAG_C] = alu_c;
      if (alu_flags_mask[FLAG_S])
        next_cpu_flags[FLAG_S] = next_cpu_flags[FLAG_N] ^
                                 next_cpu_flags[FLAG_V];
    end
    // bit store into the copy flag
    if (bit_store_op) begin
      next_cpu_flags[FLAG_T] = regs[rd_addr_a][bit_sel];
    end
    // enable set on return or set op, cleared on entry
    if (ie_set_op || irq_return_op) next_cpu_flags[FLAG_I] = 1'b1;
    if (ie_clear_op || irq_enter) next_cpu_flags[FLAG_I] = 1'b0;
  end

  // no interrupt while enable clear; clear op acts at once
  assign irq_allowed = irq_request && cpu_flags[FLAG_I] && !ie_clear_op;

  // Stack pointer next state
  // reset loads SRAM_LAST, already above 0x0100
  always_comb begin
    logic [15:0] sp;
    sp = {stack_pointer_high, stack_pointer_low};
    if (ds_req && ds_we && local_io && io_idx == IO_STACK_LOW)
      sp[7:0] = ds_wdata;
    if (ds_req && ds_we && local_io && io_idx == IO_STACK_HIGH)
      sp[15:8] = ds_wdata;
    case (sp_op)
      // one byte per push or pop
      SP_PUSH: sp = sp - SP_STEP_BYTE;
      SP_POP: sp = sp + SP_STEP_BYTE;
      SP_CALL: sp = sp - SP_STEP_RET;
      SP_RET: sp = sp + SP_STEP_RET;
      default: sp = sp;
    endcase
    next_stack_pointer_high = sp[15:8];
    next_stack_pointer_low = sp[7:0];
  end

  // Flags and stack pointer storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_flags <= FLAGS_RESET;
      stack_pointer_high <= SRAM_LAST[15:8];
      stack_pointer_low <= SRAM_LAST[7:0];
    end else begin
      cpu_flags <= next_cpu_flags;
      stack_pointer_high <= next_stack_pointer_high;
      stack_pointer_low <= next_stack_pointer_low;
    end
  end

  assign stack_pointer = {stack_pointer_high, stack_pointer_low};
endmodule : cpu_core_regs
`default_nettype wire

// ==== dv/cpu_core_regs_chk.sv ====
// Assertion checker for the working-register core, bound to its top
`timescale 1ns/1ps
`default_nettype none
module cpu_core_regs_chk import cpu_core_pkg::*; #(
  parameter logic [15:0] SRAM_LAST = 16'h20ff
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register file
  input wire wb_kind_t wb_kind,
  input wire logic [4:0] wb_addr,
  input wire logic [15:0] wb_data,
  input wire logic [4:0] rd_addr_a,
  input wire logic [7:0] rd_data_a,
  input wire logic ptr_use,
  input wire logic bit_load_op,
  input wire logic bit_store_op,
  // Data space
  input wire logic ds_req,
  input wire logic ds_direct_io,
  input wire logic [15:0] ds_addr,
  input wire logic ds_refused,
  input wire logic io_req,
  input wire logic [7:0] io_addr,
  // Flags and interrupt enable
  input wire logic alu_flags_we,
  input wire logic [7:0] alu_flags_mask,
  input wire logic irq_enter,
  input wire logic irq_return_op,
  input wire logic ie_clear_op,
  input wire logic irq_allowed,
  input wire logic [7:0] cpu_flags,
  // Stack
  input wire sp_op_t sp_op,
  input wire logic [15:0] stack_pointer
);
  // Edges since release; the core ignores requests until the third
  logic [1:0] up_cnt;
  logic [1:0] next_up_cnt;
  logic live;
  // Saturating count, so it never wraps back into the reset window
  always_comb begin
    next_up_cnt = (up_cnt == 2'h2) ? up_cnt : up_cnt + 2'h1;
  end
  // Register the count
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      up_cnt <= 2'h0;
    end else begin
      up_cnt <= next_up_cnt;
    end
  end
  assign live = (up_cnt == 2'h2);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_reset_values: assert property (
    up_cnt != 2'h2 |-> stack_pointer == SRAM_LAST && cpu_flags == 8'h00)
    else $error("reset value of stack or flags wrong");
  a_byte_writeback: assert property (
    live && wb_kind == WB_BYTE && !ptr_use && !ds_req && !bit_load_op
    |=> rd_addr_a != $past(wb_addr) || rd_data_a == 8'($past(wb_data)))
    else $error("byte result not read back");
  a_sign_flag: assert property (
    live && alu_flags_we && alu_flags_mask[FLAG_S] && !ds_req
    |=> cpu_flags[FLAG_S] == (cpu_flags[FLAG_N] ^ cpu_flags[FLAG_V]))
    else $error("sign flag not n xor v");
  a_enable_gate: assert property (
    !cpu_flags[FLAG_I] || ie_clear_op |-> !irq_allowed)
    else $error("interrupt allowed while disabled");
  a_enter_clears: assert property (
    live && irq_enter |=> !cpu_flags[FLAG_I])
    else $error("enable kept on interrupt entry");
  a_return_sets: assert property (
    live && irq_return_op && !irq_enter && !ie_clear_op |=> cpu_flags[FLAG_I])
    else $error("enable not set on return");
  a_flags_kept: assert property (
    live && (irq_enter || irq_return_op) && !alu_flags_we && !ds_req &&
    !bit_store_op |=> ((cpu_flags ^ $past(cpu_flags)) & 8'h7f) == 8'h00)
    else $error("flags changed by interrupt entry or return");
  a_stack_byte: assert property (
    live && !ds_req && (sp_op == SP_PUSH || sp_op == SP_POP)
    |=> stack_pointer == $past(stack_pointer) +
    (($past(sp_op) == SP_PUSH) ? 16'hffff : 16'h0001))
    else $error("push or pop step wrong");
  a_stack_three: assert property (
    live && !ds_req && (sp_op == SP_CALL || sp_op == SP_RET)
    |=> stack_pointer == $past(stack_pointer) +
    (($past(sp_op) == SP_CALL) ? 16'hfffd : 16'h0003))
    else $error("call or return step wrong");
  a_direct_refused: assert property (
    live && ds_req && ds_direct_io && ds_addr > 16'h003f
    |-> ds_refused && !io_req)
    else $error("direct access beyond io range taken");
  a_io_window: assert property (
    live && ds_req && !ds_direct_io && ds_addr >= 16'h0020 &&
    ds_addr < 16'h005d |-> io_req && io_addr == ds_addr[7:0])
    else $error("io window not forwarded");
endmodule : cpu_core_regs_chk
bind cpu_core_regs cpu_core_regs_chk #(.SRAM_LAST(SRAM_LAST)) u_chk (.*);
`default_nettype wire

// ==== dv/prog_io_model.sv ====
// Program memory and I/O space standing beside the core
`timescale 1ns/1ps
`default_nettype none
module prog_io_model #(
  parameter logic [15:0] PM_KEY = 16'ha5c3
) (
  // Clock
  input wire logic clk,
  // Program memory
  input wire logic [15:0] pm_addr,
  output logic [15:0] pm_data,
  // I/O space
  input wire logic io_req,
  input wire logic io_we,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata
);
  logic [7:0] mem [256]; // Peripheral bytes by data-space address
  logic [7:0] last; // Last value driven, inverted when idle
  // Word is a fixed scramble of its address, combinational
  assign pm_data = pm_addr ^ PM_KEY;
  // Idle bus shows the inverse so a stale read cannot pass
  assign io_rdata = io_req ? mem[io_addr] : ~last;
  // Stores land at the edge that takes them
  always_ff @(posedge clk) begin
    if (io_req && io_we) begin
      mem[io_addr] <= io_wdata;
    end
    if (io_req) begin
      last <= mem[io_addr];
    end
  end
endmodule : prog_io_model
`default_nettype wire

// ==== dv/tb_cpu_core_regs_status_stack.sv ====
// Self-checking bench for the working-register core
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_core_regs_status_stack import cpu_core_pkg::*;;
  logic clk = 1'b0;
  logic arst_n, insn_valid, insn_advance, jump, alu_flags_we, alu_h, alu_v;
  logic alu_n, alu_z, alu_c, bit_store_op, bit_load_op, irq_enter;
  logic irq_return_op, ie_set_op, ie_clear_op, irq_request, irq_allowed;
  logic ptr_use, ds_req, ds_we, ds_direct_io, ds_refused, io_req, io_we;
  logic sram_req;
  logic [15:0] pm_addr, pm_data, insn_word, insn_pc, jump_pc, rd_word_a;
  logic [15:0] wb_data, ptr_ea, ds_addr, sram_addr, stack_pointer;
  logic [7:0] rd_data_a, rd_data_b, alu_flags_mask, ds_wdata, ds_rdata;
  logic [7:0] io_addr, io_wdata, io_rdata, cpu_flags;
  logic [4:0] rd_addr_a, rd_addr_b, wb_addr;
  logic [2:0] bit_sel;
  logic [1:0] ptr_sel;
  logic [5:0] ptr_disp;
  wb_kind_t wb_kind;
  ptr_mode_t ptr_mode;
  sp_op_t sp_op;
  int num_errors = 0;
  int cmp_count = 0;
  cpu_core_regs dut (.*);
  prog_io_model pm (.*);
  // Free-running 100 MHz clock
  always #5 clk = ~clk;
  task automatic step();
    @(negedge clk);
  endtask : step
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Write lands within the call; wb_kind stays raised until the caller lowers it
  task automatic wr(input logic [4:0] a, input logic [15:0] d,
                    input wb_kind_t k);
    wb_kind = k;
    wb_addr = a;
    wb_data = d;
    step();
  endtask : wr
  // Raises a data-space access and lets the outputs settle
  task automatic ds(input logic [15:0] a, input logic we, input logic dir,
                    input logic [7:0] d);
    ds_req = 1'b1;
    ds_addr = a;
    ds_we = we;
    ds_direct_io = dir;
    ds_wdata = d;
    #1;
  endtask : ds
  task automatic t_fetch();
    logic [15:0] p;
    p = insn_pc;
    insn_advance = 1'b1;
    for (int i = 1; i < 5; i++) begin
      step();
      chk(insn_valid, 1'b1);
      chk(insn_pc, p + 16'(i));
      chk(insn_word, (p + 16'(i)) ^ 16'ha5c3);
    end
    insn_advance = 1'b0;
    // Redirect drops the held word for one cycle
    jump = 1'b1;
    jump_pc = 16'h0100;
    step();
    jump = 1'b0;
    chk(insn_valid, 1'b0);
    step();
    chk(insn_valid, 1'b1);
    chk(insn_pc, 16'h0100);
    chk(insn_word, 16'h0100 ^ 16'ha5c3);
  endtask : t_fetch
  task automatic t_regs();
    for (int i = 0; i < 32; i++) wr(5'(i), 16'(8'h40 + i), WB_BYTE);
    wb_kind = WB_NONE;
    for (int i = 0; i < 32; i++) begin
      rd_addr_a = 5'(i);
      rd_addr_b = 5'(31 - i);
      ds(16'(i), 1'b0, 1'b0, 8'h00);
      chk(rd_data_a, 8'(8'h40 + i));
      chk(rd_data_b, 8'(8'h5f - i));
      chk(ds_rdata, 8'(8'h40 + i));
      step();
    end
    ds_req = 1'b0;
  endtask : t_regs
  task automatic t_ptr();
    logic [4:0] base;
    for (int s = 0; s < 3; s++) begin
      base = 5'h1a + 5'(2 * s);
      wr(base, 16'h00ff, WB_WORD);
      wb_kind = WB_NONE;
      rd_addr_a = base;
      ptr_use = 1'b1;
      ptr_sel = 2'(s);
      ptr_disp = 6'h3f;
      ptr_mode = PTR_DISP;
      #1 chk(rd_word_a, 16'h00ff);
      chk(ptr_ea, 16'h013e);
      #1 ptr_mode = PTR_POSTINC;
      #1 chk(ptr_ea, 16'h00ff);
      step();
      ptr_mode = PTR_PREDEC;
      #1 chk(rd_word_a, 16'h0100);
      chk(ptr_ea, 16'h00ff);
      step();
      ptr_use = 1'b0;
      #1 chk(rd_word_a, 16'h00ff);
    end
  endtask : t_ptr
  task automatic t_flags();
    logic [4:0] v;
    alu_flags_mask = 8'h3f;
    alu_flags_we = 1'b1;
    for (int i = 0; i < 32; i++) begin
      v = 5'(i);
      {alu_h, alu_v, alu_n, alu_z, alu_c} = v;
      step();
      chk(cpu_flags, {3'b000, v[3] ^ v[2], v[3:0]} | {2'b00, v[4], 5'h0});
    end
    // Last pattern sets every arithmetic flag but sign
    chk(cpu_flags[FLAG_H], 1'b1);
    chk(cpu_flags[FLAG_V], 1'b1);
    chk(cpu_flags[FLAG_N], 1'b1);
    chk(cpu_flags[1:0], 2'b11);
    alu_flags_we = 1'b0;
    wr(5'h07, 16'h0008, WB_BYTE);
    wb_kind = WB_NONE;
    rd_addr_a = 5'h07;
    bit_sel = 3'h3;
    bit_store_op = 1'b1;
    step();
    bit_store_op = 1'b0;
    bit_load_op = 1'b1;
    wb_addr = 5'h09;
    bit_sel = 3'h1;
    step();
    bit_load_op = 1'b0;
    rd_addr_a = 5'h09;
    #1 chk(rd_data_a, 8'h4b);
    chk(cpu_flags, 8'h6f);
  endtask : t_flags
  task automatic t_irq();
    irq_request = 1'b1;
    #1 chk(irq_allowed, 1'b0);
    ie_set_op = 1'b1;
    step();
    ie_set_op = 1'b0;
    ie_clear_op = 1'b1;
    #1 chk(irq_allowed, 1'b0);
    chk(cpu_flags, 8'hef);
    step();
    ie_clear_op = 1'b0;
    ie_set_op = 1'b1;
    step();
    ie_set_op = 1'b0;
    irq_enter = 1'b1;
    #1 chk(irq_allowed, 1'b1);
    step();
    irq_enter = 1'b0;
    irq_return_op = 1'b1;
    #1 chk(cpu_flags, 8'h6f);
    step();
    irq_return_op = 1'b0;
    irq_request = 1'b0;
    #1 chk(cpu_flags, 8'hef);
  endtask : t_irq
  task automatic t_io();
    ds(16'h0020, 1'b1, 1'b0, 8'ha5);
    chk(io_addr, 8'h20);
    step();
    ds(16'h0000, 1'b0, 1'b1, 8'h00);
    chk(ds_rdata, 8'ha5);
    step();
    ds(16'h0040, 1'b1, 1'b1, 8'h11);
    chk(ds_refused, 1'b1);
    chk(io_req, 1'b0);
    step();
    // Refused short access aliasing the flags must not write them
    ds(16'h007f, 1'b1, 1'b1, 8'h00);
    chk(ds_refused, 1'b1);
    step();
    ds(16'h005f, 1'b0, 1'b0, 8'h00);
    chk(ds_rdata, 8'hef);
    chk(io_req, 1'b0);
    step();
    ds(16'h0060, 1'b1, 1'b0, 8'h3c);
    chk(io_req, 1'b1);
    step();
    ds(16'h0060, 1'b0, 1'b0, 8'h00);
    chk(ds_rdata, 8'h3c);
    step();
    // First address past the extended region goes to SRAM
    ds(16'h0100, 1'b0, 1'b0, 8'h00);
    chk(sram_req, 1'b1);
    chk(sram_addr, 16'h0100);
    chk(io_req, 1'b0);
    step();
    ds_req = 1'b0;
  endtask : t_io
  task automatic t_stack();
    sp_op_t ops [5] = '{SP_PUSH, SP_CALL, SP_POP, SP_RET, SP_RET};
    logic [15:0] dl [5] = '{16'hffff, 16'hfffd, 16'h0001, 16'h0003, 16'h0003};
    logic [15:0] e;
    e = 16'h0800;
    ds(16'h005e, 1'b1, 1'b0, 8'h08);
    step();
    // stack placed above the I/O region
    ds(16'h005d, 1'b1, 1'b0, 8'h00);
    step();
    ds_req = 1'b0;
    chk(stack_pointer, e);
    for (int i = 0; i < 5; i++) begin
      sp_op = ops[i];
      step();
      e = e + dl[i];
      chk(stack_pointer, e);
    end
    sp_op = SP_NONE;
  endtask : t_stack
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  // Main sequence: reset, then one task per scenario
  initial begin
    arst_n = 1'b0;
    {insn_advance, jump, alu_flags_we, alu_h, alu_v, alu_n, alu_z} = '0;
    {alu_c, bit_store_op, bit_load_op, irq_enter, irq_return_op} = '0;
    {ie_set_op, ie_clear_op, irq_request, ptr_use, ds_req, ds_we} = '0;
    {ds_direct_io, jump_pc, wb_data, ds_addr, ds_wdata, ptr_disp} = '0;
    {alu_flags_mask, rd_addr_a, rd_addr_b, wb_addr, bit_sel, ptr_sel} = '0;
    wb_kind = WB_NONE;
    ptr_mode = PTR_DISP;
    sp_op = SP_NONE;
    repeat (5) step();
    arst_n = 1'b1;
    repeat (3) step();
    chk(stack_pointer, 16'h20ff);
    chk(cpu_flags, 8'h00);
    t_fetch();
    t_regs();
    t_ptr();
    t_flags();
    t_irq();
    t_io();
    t_stack();
    // Mid-run reset brings the stack and flags back
    arst_n = 1'b0;
    step();
    arst_n = 1'b1;
    repeat (3) step();
    chk(stack_pointer, 16'h20ff);
    chk(cpu_flags, 8'h00);
    close_out();
  end
  // Watchdog well beyond the roughly 150 cycles the run needs
  initial begin
    #20us;
    num_errors++;
    close_out();
  end
endmodule : tb_cpu_core_regs_status_stack
`default_nettype wire
